/* File: pixro_capture_model.sv */
/* capture side model: counts frames and lines, checks idle words in line gaps.
   assumes lanes, valid and frame start flopped on the same clock. */
`timescale 1ns/100ps
module pixro_capture_model (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire pixro_pkg::lanes_t i_lanes,
  input wire logic i_valid,
  input wire logic i_frame_start,
  input wire logic i_busy,
  input wire logic [11:0] i_idle_exp,
  output logic [15:0] o_frames,
  output logic [15:0] o_lines,
  output logic [15:0] o_idle_err
);
  import pixro_pkg::*;
  logic valid_q;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      valid_q <= 1'b0;
      o_frames <= 16'h0;
      o_lines <= 16'h0;
      o_idle_err <= 16'h0;
    end else begin
      valid_q <= i_valid;
      o_frames <= o_frames + 16'(i_frame_start);
      o_lines <= o_lines + 16'(i_valid && !valid_q);
      o_idle_err <= o_idle_err + 16'(i_busy && !i_valid && i_lanes != {LANES{i_idle_exp}});
    end
  end
endmodule : pixro_capture_model

/* File: pixro_lane_mux.sv */
/*
 * per-lane output stage: pixel data on active lanes while valid,
 * otherwise the idle training word, trimmed to the pixel depth.
 * assumes pixel words arrive on the same clock, aligned with i_valid.
 */
`timescale 1ns/100ps
module pixro_lane_mux (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_valid,
  input wire pixro_pkg::chan_mode_e i_chan,
  input wire logic [11:0] i_train,
  input wire logic i_depth10,
  input wire pixro_pkg::lanes_t i_pix,
  output pixro_pkg::lanes_t o_lanes
);
  import pixro_pkg::*;

  pixro_pkg::lanes_t lanes_d;
  pixro_pkg::lanes_t lanes_q;
  wire logic [PIX_W-1:0] depth_mask = i_depth10 ? 12'h3ff : 12'hfff;
  wire logic [4:0] active_lanes = lane_count(i_chan);

  always_comb begin
    for (int c = 0; c < LANES; c++) begin
      if (i_valid && (5'(c) < active_lanes)) begin
        lanes_d[c] = i_pix[c] & depth_mask;
      end else begin
        lanes_d[c] = i_train & depth_mask;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lanes_q <= '0;
    end else begin
      lanes_q <= lanes_d;
    end
  end

  assign o_lanes = lanes_q;

endmodule : pixro_lane_mux

/* File: pixro_pkg.sv */
/*
 * shared constants, types and helpers for the readout-order block.
 * assumes register indices sit on word boundaries: byte address = 4 * index.
 */
package pixro_pkg;

  // ************************************************************
  // geometry and timing
  // ************************************************************
  localparam int unsigned ROWS = 1088;
  localparam int unsigned COLS = 2048;
  localparam int unsigned LANES = 16;
  localparam int unsigned PIX_W = 12;
  localparam int unsigned ROW_W = 11;
  localparam int unsigned LINE_GAP = 8;
  localparam logic [ROW_W-1:0] ROW_FIRST = 11'h000;
  localparam logic [ROW_W-1:0] ROW_LAST = 11'h43f;

  // ************************************************************
  // register indices (byte address = index * 4)
  // ************************************************************
  localparam logic [7:0] IDX_LINES = 8'h01;
  localparam logic [7:0] IDX_SKIP_P = 8'h23;
  localparam logic [7:0] IDX_SKIP_A = 8'h25;
  localparam logic [7:0] IDX_MIRROR = 8'h28;
  localparam logic [7:0] IDX_BURST = 8'h46;
  localparam logic [7:0] IDX_CHAN = 8'h48;
  localparam logic [7:0] IDX_TRAIN = 8'h4e;
  localparam logic [7:0] IDX_DEPTH = 8'h6f;
  localparam logic [7:0] IDX_CTRL = 8'h80;
  localparam logic [7:0] IDX_STAT = 8'h81;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [15:0] RST_LINES = 16'h0440;
  localparam logic [15:0] RST_SKIP = 16'h0000;
  localparam logic [1:0] RST_MIRROR = 2'h0;
  localparam logic [15:0] RST_BURST = 16'h0001;
  localparam logic [1:0] RST_CHAN = 2'h0;
  localparam logic [11:0] RST_TRAIN = 12'h055;
  localparam logic RST_DEPTH10 = 1'b1;
  localparam int unsigned MIR_X_BIT = 0;
  localparam int unsigned MIR_Y_BIT = 1;
  localparam int unsigned CTRL_INTEXP_BIT = 0;
  localparam int unsigned CTRL_REQ_BIT = 1;

  typedef enum logic [1:0] {CH16, CH8, CH4, CH2} chan_mode_e;

  typedef struct packed {
    logic [1:0] mirror;
    logic [15:0] skip_p;
    logic [15:0] skip_a;
    logic [15:0] lines;
    logic [15:0] burst;
    chan_mode_e chan;
    logic [11:0] train;
    logic depth10;
  } cfg_s;

  typedef logic [LANES-1:0][PIX_W-1:0] lanes_t;

  // pixels per channel per line: 128, 256, 512, 1024
  function automatic logic [ROW_W-1:0] chan_width(input chan_mode_e m);
    chan_width = ROW_W'(11'h080 << m);
  endfunction : chan_width

  // number of active lanes: 16, 8, 4, 2
  function automatic logic [4:0] lane_count(input chan_mode_e m);
    lane_count = 5'(5'h10 >> m);
  endfunction : lane_count

endpackage : pixro_pkg

/* File: pixro_readout.sv */
/*
 * readout-order sequencer with apb register file: mirroring, row skipping,
 * frame bursts, lane count selection and idle training word.
 * assumes apb master on i_sys_clk; i_frame_req_pin is asynchronous.
 */
`timescale 1ns/100ps
module pixro_readout (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_frame_req_pin,
  input wire pixro_pkg::lanes_t i_pix,
  output pixro_pkg::lanes_t o_lanes,
  output logic o_pix_valid,
  output logic [10:0] o_row,
  output logic [10:0] o_col,
  output logic o_frame_start,
  output logic o_busy
);
  import pixro_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [15:0] wr16(input logic [15:0] old, input logic [7:0] idx,
                                       input logic [7:0] base, input logic [7:0] data);
    wr16 = old;
    if (idx == base) begin
      wr16[7:0] = data;
    end else if (idx == base + 8'h01) begin
      wr16[15:8] = data;
    end
  endfunction : wr16

  function automatic logic [ROW_W-1:0] step_row(input logic [ROW_W-1:0] row,
                                               input logic [15:0] skip, input logic up);
    logic [16:0] adv;
    logic [16:0] pos;
    adv = 17'(skip) + 17'h00001;
    adv = 17'(adv % 17'(ROWS));
    if (up) begin
      pos = 17'(row) + 17'(ROWS) - adv;
    end else begin
      pos = 17'(row) + adv;
    end
    step_row = ROW_W'(pos % 17'(ROWS));
  endfunction : step_row

  // ************************************************************
  // frame request pin synchroniser
  // ************************************************************
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic req_lvl_q;
  wire logic req_lvl_d = (req_s2_q == req_s3_q) ? req_s3_q : req_lvl_q;
  wire logic pin_req = req_lvl_d & ~req_lvl_q;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      req_lvl_q <= 1'b0;
    end else begin
      req_s1_q <= i_frame_req_pin;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      req_lvl_q <= req_lvl_d;
    end
  end

  // ************************************************************
  // apb register file
  // ************************************************************
  cfg_s cfg_q;
  cfg_s cfg_d;
  logic intexp_q;
  logic [15:0] frames_sent_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic pready_q;
  logic busy_q;

  wire logic [7:0] idx = i_paddr[9:2];
  wire logic [7:0] wbyte = i_pwdata[7:0];
  wire logic setup = i_psel & ~i_penable;
  wire logic hit16 = (idx == IDX_LINES) || (idx == IDX_LINES + 8'h01) ||
                     (idx == IDX_SKIP_P) || (idx == IDX_SKIP_P + 8'h01) ||
                     (idx == IDX_SKIP_A) || (idx == IDX_SKIP_A + 8'h01) ||
                     (idx == IDX_BURST) || (idx == IDX_BURST + 8'h01) ||
                     (idx == IDX_TRAIN) || (idx == IDX_TRAIN + 8'h01);
  wire logic hit8 = (idx == IDX_MIRROR) || (idx == IDX_CHAN) || (idx == IDX_DEPTH) ||
                    (idx == IDX_CTRL) || (idx == IDX_STAT);
  wire logic mapped = (i_paddr[31:10] == 22'h000000) && (i_paddr[1:0] == 2'h0) && (hit16 || hit8);
  // refused addresses must not write an aliased index; a refused read at the status index still returns the status word
  wire logic wr_en = i_psel & i_penable & i_pwrite & mapped;
  wire logic [15:0] train16 = {4'h0, cfg_q.train};
  wire logic sw_req = wr_en && (idx == IDX_CTRL) && wbyte[CTRL_REQ_BIT];

  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      IDX_LINES: rd_byte = cfg_q.lines[7:0];
      IDX_LINES + 8'h01: rd_byte = cfg_q.lines[15:8];
      IDX_SKIP_P: rd_byte = cfg_q.skip_p[7:0];
      IDX_SKIP_P + 8'h01: rd_byte = cfg_q.skip_p[15:8];
      IDX_SKIP_A: rd_byte = cfg_q.skip_a[7:0];
      IDX_SKIP_A + 8'h01: rd_byte = cfg_q.skip_a[15:8];
      IDX_MIRROR: rd_byte = {6'h00, cfg_q.mirror};
      IDX_BURST: rd_byte = cfg_q.burst[7:0];
      IDX_BURST + 8'h01: rd_byte = cfg_q.burst[15:8];
      IDX_CHAN: rd_byte = {6'h00, cfg_q.chan};
      IDX_TRAIN: rd_byte = train16[7:0];
      IDX_TRAIN + 8'h01: rd_byte = train16[15:8];
      IDX_DEPTH: rd_byte = {7'h00, cfg_q.depth10};
      IDX_CTRL: rd_byte = {7'h00, intexp_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    logic [15:0] t;
    t = 16'h0000;
    cfg_d = cfg_q;
    if (wr_en) begin
      cfg_d.lines = wr16(cfg_q.lines, idx, IDX_LINES, wbyte);
      cfg_d.skip_p = wr16(cfg_q.skip_p, idx, IDX_SKIP_P, wbyte);
      cfg_d.skip_a = wr16(cfg_q.skip_a, idx, IDX_SKIP_A, wbyte);
      cfg_d.burst = wr16(cfg_q.burst, idx, IDX_BURST, wbyte);
      t = wr16(train16, idx, IDX_TRAIN, wbyte);
      cfg_d.train = t[11:0];
      if (idx == IDX_MIRROR) begin
        cfg_d.mirror = wbyte[1:0];
      end
      if (idx == IDX_CHAN) begin
        cfg_d.chan = chan_mode_e'(wbyte[1:0]);
      end
      if (idx == IDX_DEPTH) begin
        cfg_d.depth10 = wbyte[0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cfg_q <= '{mirror: RST_MIRROR, skip_p: RST_SKIP, skip_a: RST_SKIP, lines: RST_LINES,
                 burst: RST_BURST, chan: CH16, train: RST_TRAIN, depth10: RST_DEPTH10};
      intexp_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      pready_q <= 1'b1;
      if (wr_en && (idx == IDX_CTRL)) begin
        intexp_q <= wbyte[CTRL_INTEXP_BIT];
      end
      if (setup) begin
        pslverr_q <= ~mapped;
        if (idx == IDX_STAT) begin
          prdata_q <= {frames_sent_q, 15'h0000, busy_q};
        end else begin
          prdata_q <= mapped ? {24'h000000, rd_byte} : 32'h00000000;
        end
      end
    end
  end

  // ************************************************************
  // row and column sequencer
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LINE, ST_GAP} seq_e;
  seq_e state_q;
  logic [ROW_W-1:0] row_q;
  logic [ROW_W-1:0] col_q;
  logic [3:0] gap_q;
  logic [15:0] lines_q;
  logic [15:0] left_q;
  logic odd_q;
  logic fstart_q;
  logic valid_q;
  logic [ROW_W-1:0] orow_q;
  logic [ROW_W-1:0] ocol_q;

  wire logic start_req = pin_req | sw_req;
  wire logic [ROW_W-1:0] ch_w = chan_width(cfg_q.chan);
  wire logic [ROW_W-1:0] row_start = cfg_q.mirror[MIR_Y_BIT] ? ROW_LAST : ROW_FIRST;
  wire logic [15:0] burst_eff = (cfg_q.burst == 16'h0000) ? 16'h0001 : cfg_q.burst;
  wire logic [15:0] lines_eff = (cfg_q.lines == 16'h0000) ? 16'h0001 : cfg_q.lines;
  // even lines use the primary skip, odd lines the alternate; primary 0 keeps row pairs
  wire logic [15:0] skip_now = odd_q ? cfg_q.skip_a : cfg_q.skip_p;
  wire logic [ROW_W-1:0] row_next = step_row(row_q, skip_now, cfg_q.mirror[MIR_Y_BIT]);
  wire logic [ROW_W-1:0] col_out = cfg_q.mirror[MIR_X_BIT] ? (ch_w - 11'h001 - col_q) : col_q;
  wire logic line_end = (state_q == ST_LINE) && (col_q == ch_w - 11'h001);
  wire logic gap_end = (state_q == ST_GAP) && (gap_q == 4'(LINE_GAP - 1));
  wire logic frame_done = gap_end && (lines_q >= lines_eff);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      row_q <= ROW_FIRST;
      col_q <= 11'h000;
      gap_q <= 4'h0;
      lines_q <= 16'h0000;
      left_q <= 16'h0000;
      odd_q <= 1'b0;
      frames_sent_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_req) begin
            left_q <= intexp_q ? burst_eff : 16'h0001;
            row_q <= row_start;
            col_q <= 11'h000;
            lines_q <= 16'h0000;
            odd_q <= 1'b0;
            state_q <= ST_LINE;
          end
        end
        ST_LINE: begin
          col_q <= col_q + 11'h001;
          if (line_end) begin
            gap_q <= 4'h0;
            lines_q <= lines_q + 16'h0001;
            row_q <= row_next;
            odd_q <= ~odd_q;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          gap_q <= gap_q + 4'h1;
          col_q <= 11'h000;
          if (frame_done) begin
            frames_sent_q <= frames_sent_q + 16'h0001;
            left_q <= left_q - 16'h0001;
            row_q <= row_start;
            lines_q <= 16'h0000;
            odd_q <= 1'b0;
            state_q <= (left_q == 16'h0001) ? ST_IDLE : ST_LINE;
          end else if (gap_end) begin
            state_q <= ST_LINE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  wire logic valid_now = (state_q == ST_LINE);
  wire logic fstart_now = valid_now && (col_q == 11'h000) && (lines_q == 16'h0000);

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      valid_q <= 1'b0;
      fstart_q <= 1'b0;
      orow_q <= 11'h000;
      ocol_q <= 11'h000;
      busy_q <= 1'b0;
    end else begin
      valid_q <= valid_now;
      fstart_q <= fstart_now;
      orow_q <= row_q;
      ocol_q <= col_out;
      busy_q <= (state_q != ST_IDLE) || start_req;
    end
  end

  pixro_lane_mux u_lanes (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_valid(valid_now),
    .i_chan(cfg_q.chan),
    .i_train(cfg_q.train),
    .i_depth10(cfg_q.depth10),
    .i_pix(i_pix),
    .o_lanes(o_lanes)
  );

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_pix_valid = valid_q;
  assign o_row = orow_q;
  assign o_col = ocol_q;
  assign o_frame_start = fstart_q;
  assign o_busy = busy_q;

endmodule : pixro_readout

/* File: pixro_readout_props.sv */
/* port checker for pixro_readout, attached by bind below.
   assumes zero-wait apb and the line and gap timing of the frame stream. */
`timescale 1ns/100ps
module pixro_readout_props (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_frame_req_pin,
  input wire pixro_pkg::lanes_t i_pix,
  input wire pixro_pkg::lanes_t o_lanes,
  input wire logic o_pix_valid,
  input wire logic [10:0] o_row,
  input wire logic [10:0] o_col,
  input wire logic o_frame_start,
  input wire logic o_busy
);
  import pixro_pkg::*;
  // ************************************************************
  // bus and stream relations
  // ************************************************************
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);
  a_apb_no_wait: assert property (i_psel && i_penable |-> o_pready)
    else $error("pready low in access phase");
  a_misalign_err: assert property (i_psel && i_penable && i_paddr[1:0] != 2'h0 |-> o_pslverr)
    else $error("misaligned access without error");
  a_idle_lanes: assert property (!o_pix_valid |-> o_lanes == {LANES{o_lanes[0]}})
    else $error("idle lanes differ");
  a_start_valid: assert property (o_frame_start |-> o_pix_valid && o_busy)
    else $error("frame start outside valid burst");
  a_start_row: assert property (o_frame_start |-> o_row == ROW_FIRST || o_row == ROW_LAST)
    else $error("frame starts on wrong row");
  a_start_col: assert property (o_frame_start |-> o_col inside {11'h000, 11'h07f, 11'h0ff, 11'h1ff, 11'h3ff})
    else $error("frame starts on wrong column");
  a_start_pulse: assert property (o_frame_start |=> !o_frame_start)
    else $error("frame start longer than one cycle");
  a_col_step: assert property (o_pix_valid && $past(o_pix_valid) |->
    o_col == $past(o_col) + 11'h1 || o_col == $past(o_col) - 11'h1)
    else $error("column does not step by one");
  a_row_hold: assert property (o_pix_valid && $past(o_pix_valid) |-> $stable(o_row))
    else $error("row changed inside a line");
  a_line_gap: assert property ($fell(o_pix_valid) |-> !o_pix_valid [*8])
    else $error("line gap too short");
  c_frame: cover property (o_frame_start);
  c_err: cover property (i_psel && i_penable && o_pslverr);
  c_gap: cover property ($fell(o_pix_valid));
endmodule : pixro_readout_props

bind pixro_readout pixro_readout_props props_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_frame_req_pin(i_frame_req_pin), .i_pix(i_pix),
  .o_lanes(o_lanes), .o_pix_valid(o_pix_valid), .o_row(o_row), .o_col(o_col), .o_frame_start(o_frame_start),
  .o_busy(o_busy));

/* File: pixro_readout_tb.sv */
/* self-checking bench for pixro_readout: registers, readout order, bursts.
   assumes the props checker and capture model are compiled with it. */
`timescale 1ns/100ps
module pixro_readout_tb;
  import pixro_pkg::*;
  logic i_sys_clk, i_rstn, psel, penable, pwrite, pready, pslverr, req_pin, pix_valid, frame_start, busy, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  lanes_t pix, lanes;
  logic [10:0] row, col;
  logic [11:0] idle_exp;
  logic [15:0] m_frames, m_lines, m_idle_err;
  int fail_count, tests_run;
  logic [7:0] rst_idx [13] = '{8'h01, 8'h02, 8'h23, 8'h24, 8'h25, 8'h26, 8'h28, 8'h46, 8'h47, 8'h48, 8'h4e, 8'h4f, 8'h6f};
  logic [7:0] rst_val [13] = '{8'h40, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h55, 8'h00, 8'h01};

  pixro_readout dut_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_frame_req_pin(req_pin), .i_pix(pix), .o_lanes(lanes), .o_pix_valid(pix_valid),
    .o_row(row), .o_col(col), .o_frame_start(frame_start), .o_busy(busy));
  pixro_capture_model cap_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_lanes(lanes), .i_valid(pix_valid),
    .i_frame_start(frame_start), .i_busy(busy), .i_idle_exp(idle_exp), .o_frames(m_frames), .o_lines(m_lines),
    .o_idle_err(m_idle_err));

  // ************************************************************
  // bus tasks and checks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {22'h0, idx, 2'h0}, d);
  endtask : wr

  task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
    wr(idx, v[7:0]);
    wr(idx + 8'h1, v[15:8]);
  endtask : wr16

  task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, {22'h0, idx, 2'h0}, 8'h0);
    chk(what, exp, rd);
  endtask : rdc

  task automatic wait_idle();
    for (int n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge i_sys_clk);
    chk("busy end", 32'h0, 32'(busy));
  endtask : wait_idle

  // three lines, skips 1 then 2, mirror and lane mode both m
  task automatic readout(input logic [1:0] m);
    int n;
    int w;
    int r;
    w = 128 << m;
    r = m[1] ? 1087 : 0;
    wr(IDX_MIRROR, {6'h0, m});
    wr(IDX_CHAN, {6'h0, m});
    wr(IDX_CTRL, 8'h02);
    for (int ln = 0; ln < 3; ln++) begin
      for (n = 0; n < 3000 && pix_valid !== 1'b1; n++) @(posedge i_sys_clk);
      chk("row", r, 32'(row));
      if (ln == 0) begin
        chk("frame start", 32'h1, 32'(frame_start));
        chk("first col", m[0] ? w - 1 : 0, 32'(col));
        chk("lane0 pixel", 32'h300, 32'(lanes[0]));
        chk("edge lane", m == 2'h0 ? 32'h30f : 32'h2bc, 32'(lanes[m == 2'h0 ? 15 : 16 >> m]));
      end
      n = 1;
      while (n < 2000) begin
        @(posedge i_sys_clk);
        if (pix_valid !== 1'b1) break;
        n++;
      end
      chk("line length", w, n);
      r = m[1] ? r - (ln == 0 ? 2 : 3) : r + (ln == 0 ? 2 : 3);
    end
    wait_idle();
  endtask : readout

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    #500000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    {i_rstn, psel, penable, pwrite, req_pin} = 5'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    idle_exp = 12'h2bc;
    fail_count = 0;
    tests_run = 0;
    for (int c = 0; c < LANES; c++) pix[c] = 12'hf00 | 12'(c);
    repeat (2) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    chk("reset idle word", 32'h055, 32'(lanes[0]));
    for (int i = 0; i < 13; i++) rdc("reset value", rst_idx[i], 32'(rst_val[i]));
    apb(1'b0, 32'h0000_03fc, 8'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    apb(1'b0, 32'h0000_0005, 8'h0);
    chk("misaligned err", 32'h1, 32'(err));
    wr16(IDX_TRAIN, 16'h0abc);
    rdc("train low", IDX_TRAIN, 32'hbc);
    rdc("train high", IDX_TRAIN + 8'h1, 32'h0a);
    wr(IDX_DEPTH, 8'h00);
    repeat (2) @(posedge i_sys_clk);
    chk("idle 12 bit", 32'habc, 32'(lanes[3]));
    wr(IDX_DEPTH, 8'h01);
    repeat (2) @(posedge i_sys_clk);
    chk("idle 10 bit", 32'h2bc, 32'(lanes[9]));
    wr16(IDX_LINES, 16'h0003);
    rdc("lines high", IDX_LINES + 8'h1, 32'h0);
    wr16(IDX_SKIP_P, 16'h0001);
    wr16(IDX_SKIP_A, 16'h0002);
    for (int m = 0; m < 4; m++) readout(2'(m));
    wr16(IDX_LINES, 16'h0002);
    wr16(IDX_SKIP_P, 16'h0000);
    wr16(IDX_SKIP_A, 16'h0002);
    wr(IDX_MIRROR, 8'h00);
    wr(IDX_CHAN, 8'h00);
    wr16(IDX_BURST, 16'h0002);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_CTRL, 8'h03);
    apb(1'b0, {22'h0, IDX_STAT, 2'h0}, 8'h0);
    chk("busy", 32'h1, 32'(rd[0]));
    wr(IDX_CTRL, 8'h03);
    // advanced skip: second line is the pair row of the first
    for (int n = 0; n < 400 && !(pix_valid === 1'b1 && row !== 11'h000); n++) @(posedge i_sys_clk);
    chk("pair row", 32'h1, 32'(row));
    wait_idle();
    chk("burst frames", 32'd6, 32'(m_frames));
    wr(IDX_CTRL, 8'h00);
    @(posedge i_sys_clk);
    req_pin <= 1'b1;
    for (int n = 0; n < 50 && busy !== 1'b1; n++) @(posedge i_sys_clk);
    req_pin <= 1'b0;
    wait_idle();
    chk("frames", 32'd7, 32'(m_frames));
    chk("lines", 32'd18, 32'(m_lines));
    chk("gap idle errors", 32'h0, 32'(m_idle_err));
    wr(IDX_STAT, 8'hff);
    chk("status write err", 32'h0, 32'(err));
    apb(1'b0, {22'h0, IDX_STAT, 2'h0}, 8'h0);
    chk("frames sent", 32'd7, 32'(rd[31:16]));
    tally_and_finish();
  end
endmodule : pixro_readout_tb
